// >>> hise_top.sv
// Interrupt status flags, source enables and IRQ output of the host core
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Frame start sets bit 1 flag
// - Reserved bits 2,0 read 0, later 1
// - Frame start IRQ only when bit 1 enabled
// - Isochronous IRQ only when bit 9 enabled
// - Async list IRQ only when bit 8 enabled
// - Interrupt transfer IRQ only when bit 7 enabled
// - Clock stable IRQ only when bit 6 enabled
// - Suspend entry IRQ only when bit 5 enabled
// - DMA done IRQ only when bit 3 enabled
// - Descriptor completions set bits 9, 8, 7
// - Stable clocks set bit 6 flag
// - Suspend sets bit 5, DMA bit 3
module hise_top #(
	parameter int ADDR_W = 16,                        // Processor address width
	parameter int SETTLE = hise_pkg::SETTLE_CYC       // Reserved bit settle cycles
) (
	input  wire  logic              clock_i,          // Core clock, 250 MHz
	input  wire  logic              srst_i,           // Synchronous reset
	input  wire  logic              bus_sel_i,        // Register access select
	input  wire  logic              bus_wr_i,         // Write strobe
	input  wire  logic              bus_rd_i,         // Read strobe
	input  wire  logic [ADDR_W-1:0] bus_addr_i,       // Byte address
	input  wire  logic [31:0]       bus_wdata_i,      // Write data
	output logic       [31:0]       bus_rdata_o,      // Read data, registered
	input  wire  logic              frame_start_i,    // Frame start pulse
	input  wire  logic              iso_done_i,       // Isochronous match done
	input  wire  logic              async_done_i,     // Async list match done
	input  wire  logic              intr_done_i,      // Interrupt transfer match done
	input  wire  logic              clk_stable_i,     // Internal clocks stable
	input  wire  logic              suspend_entry_i,  // Suspend entered
	input  wire  logic              dma_done_i,       // DMA transfer complete
	output logic                    irq_o             // IRQ line, active high
);

	// Refuse an address too narrow for the register offsets
	if (ADDR_W < 10) begin : g_bad_addr
		$error("hise_top: ADDR_W must be at least 10");
	end
	// Refuse a settle time the counter cannot hold
	if (SETTLE < 1 || SETTLE > 4096) begin : g_bad_settle
		$error("hise_top: SETTLE must lie in 1..4096");
	end

	localparam int CNT_W = $clog2(SETTLE + 1);        // Settle counter width
	localparam logic [CNT_W-1:0] SETTLE_END = CNT_W'(SETTLE);

	// Address decode, shared by read and write paths
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	// Decoded accesses
	logic wr_flags;       // Write to the status register
	logic wr_en;          // Write to the enable register
	logic rd_any;         // Any read access

	// Decode write strobes against the two offsets; the read strobe takes any address
	always_comb begin
		wr_flags = bus_sel_i && bus_wr_i && hit(bus_addr_i, hise_pkg::IRQ_EVENT_FLAGS_OFS);
		wr_en    = bus_sel_i && bus_wr_i && hit(bus_addr_i, hise_pkg::IRQ_SOURCE_ENABLES_OFS);
		rd_any   = bus_sel_i && bus_rd_i;
	end

	// Event vector laid out at register bit positions
	logic [31:0] ev_set;      // Set pulses per bit
	logic [31:0] ev_clr;      // Write-one-to-clear pulses per bit
	logic [31:0] flags;       // Sticky flags from the bank

	// Map events onto their flag positions
	always_comb begin
		ev_set = '0;
		ev_set[hise_pkg::SOF_BIT]   = frame_start_i;
		ev_set[hise_pkg::ISO_BIT]   = iso_done_i;
		ev_set[hise_pkg::ASYNC_BIT] = async_done_i;
		ev_set[hise_pkg::INTR_BIT]  = intr_done_i;
		ev_set[hise_pkg::CLK_BIT]   = clk_stable_i;
		ev_set[hise_pkg::SUSP_BIT]  = suspend_entry_i;
		ev_set[hise_pkg::DMA_BIT]   = dma_done_i;
		// Ones written to live bits clear them; reserved bits ignore writes
		ev_clr = wr_flags ? (bus_wdata_i & hise_pkg::SRC_MASK) : '0;
	end

	// Sticky flags; a set in the clearing cycle wins
	hise_flag_bank #(
		.WIDTH   (32)
	) u_flags (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.set_i   (ev_set),
		.clr_i   (ev_clr),
		.flags_o (flags)
	);

	// Enable register state
	logic [31:0] en_ff;       // Source enables
	logic [31:0] nxt_en;      // Next source enables

	// Only live enable bits are stored; reserved enables read zero
	always_comb begin
		nxt_en = en_ff;
		if (wr_en) begin
			nxt_en = bus_wdata_i & hise_pkg::SRC_MASK;
		end
	end

	// Register the enables; reset clears every source
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			en_ff <= hise_pkg::ENABLES_RST;
		end else begin
			en_ff <= nxt_en;
		end
	end

	// Reserved status bits settle state
	logic [CNT_W-1:0] settle_ff;      // Cycles since reset release
	logic [CNT_W-1:0] nxt_settle;     // Next count
	logic             rsvd_one_ff;    // Reserved bits now read one
	logic             nxt_rsvd_one;   // Next reserved level

	// Count from reset until the reserved bits turn to one
	always_comb begin
		nxt_settle   = settle_ff;
		nxt_rsvd_one = rsvd_one_ff;
		if (!rsvd_one_ff) begin
			if (settle_ff == SETTLE_END - CNT_W'(1)) begin
				nxt_rsvd_one = 1'b1;
			end else begin
				nxt_settle = settle_ff + CNT_W'(1);
			end
		end
	end

	// Register the settle state; reset brings the bits back to zero
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			settle_ff   <= '0;
			rsvd_one_ff <= 1'b0;
		end else begin
			settle_ff   <= nxt_settle;
			rsvd_one_ff <= nxt_rsvd_one;
		end
	end

	// Full status word as software sees it
	logic [31:0] status_word;     // Flags plus reserved bits

	// Reserved bits 2 and 0 follow the settle level; bit 4 reads zero
	always_comb begin
		status_word = flags & hise_pkg::SRC_MASK;
		status_word[hise_pkg::RSVD2_BIT] = rsvd_one_ff;
		status_word[hise_pkg::RSVD0_BIT] = rsvd_one_ff;
	end

	// Read data and IRQ state
	logic [31:0] rdata_ff;        // Read data register
	logic [31:0] nxt_rdata;       // Next read data
	logic        irq_ff;          // IRQ line register
	logic        nxt_irq;         // Next IRQ level

	// Read mux and IRQ combine
	always_comb begin
		nxt_rdata = rdata_ff;
		if (rd_any) begin
			if (hit(bus_addr_i, hise_pkg::IRQ_EVENT_FLAGS_OFS)) begin
				nxt_rdata = status_word;
			end else if (hit(bus_addr_i, hise_pkg::IRQ_SOURCE_ENABLES_OFS)) begin
				nxt_rdata = en_ff;
			end else begin
				nxt_rdata = '0;                               // Unmapped reads zero
			end
		end
		// Each flag reaches the line only through its own enable
		nxt_irq = |(flags & en_ff & hise_pkg::SRC_MASK);
	end

	// Register read data and IRQ
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rdata_ff <= '0;
			irq_ff   <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			irq_ff   <= nxt_irq;
		end
	end

	assign bus_rdata_o = rdata_ff;
	assign irq_o       = irq_ff;

	// Checks run on the core clock and rest during reset
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	// An event pulse followed by one more cycle
	sequence s_event(logic ev);
		ev ##1 1'b1;
	endsequence

	// Event sets its flag by the next edge
	property p_sets(logic ev, int b);
		s_event(ev) |-> flags[b];
	endproperty

	// Enabled flag drives the line next cycle; disabled one alone does not
	property p_gate(int b);
		(flags[b] && en_ff[b]) |=> irq_o;
	endproperty

	property p_mute(int b);
		(flags[b] && !en_ff[b] && ((flags & en_ff) == 32'h0000_0000)) |=> !irq_o;
	endproperty

	a_sof_sets_flag:    assert property (p_sets(frame_start_i, hise_pkg::SOF_BIT))
		else $error("frame start did not set its flag");
	a_sof_no_spurious:  assert property ($rose(flags[hise_pkg::SOF_BIT]) |-> $past(frame_start_i))
		else $error("frame start flag rose without a frame start");
	a_rsvd_low_early:   assert property (!rsvd_one_ff |-> (status_word[2] == 1'b0 && status_word[0] == 1'b0))
		else $error("reserved bits read one before settling");
	a_rsvd_rise_time:   assert property ($rose(rsvd_one_ff) |-> $past(settle_ff) == SETTLE_END - CNT_W'(1))
		else $error("reserved bits rose at the wrong count");
	a_rsvd_stay_high:   assert property (rsvd_one_ff |=> rsvd_one_ff)
		else $error("reserved bits fell back without reset");
	a_sof_irq_gate:     assert property (p_gate(hise_pkg::SOF_BIT))
		else $error("enabled frame start gave no IRQ");
	a_sof_irq_mute:     assert property (p_mute(hise_pkg::SOF_BIT))
		else $error("disabled frame start raised IRQ");
	a_iso_irq_gate:     assert property (p_gate(hise_pkg::ISO_BIT))
		else $error("enabled isochronous flag gave no IRQ");
	a_async_irq_gate:   assert property (p_gate(hise_pkg::ASYNC_BIT))
		else $error("enabled async flag gave no IRQ");
	a_intr_irq_gate:    assert property (p_gate(hise_pkg::INTR_BIT))
		else $error("enabled interrupt transfer flag gave no IRQ");
	a_clk_irq_gate:     assert property (p_gate(hise_pkg::CLK_BIT))
		else $error("enabled clock stable flag gave no IRQ");
	a_susp_irq_gate:    assert property (p_gate(hise_pkg::SUSP_BIT))
		else $error("enabled suspend flag gave no IRQ");
	a_dma_irq_gate:     assert property (p_gate(hise_pkg::DMA_BIT))
		else $error("enabled DMA flag gave no IRQ");
	a_iso_sets_flag:    assert property (p_sets(iso_done_i, hise_pkg::ISO_BIT))
		else $error("isochronous completion did not set its flag");
	a_async_sets_flag:  assert property (p_sets(async_done_i, hise_pkg::ASYNC_BIT))
		else $error("async completion did not set its flag");
	a_intr_sets_flag:   assert property (p_sets(intr_done_i, hise_pkg::INTR_BIT))
		else $error("interrupt transfer completion did not set its flag");
	a_clk_sets_flag:    assert property (p_sets(clk_stable_i, hise_pkg::CLK_BIT))
		else $error("clock stable did not set its flag");
	a_susp_sets_flag:   assert property (p_sets(suspend_entry_i, hise_pkg::SUSP_BIT))
		else $error("suspend entry did not set its flag");
	a_dma_sets_flag:    assert property (p_sets(dma_done_i, hise_pkg::DMA_BIT))
		else $error("DMA completion did not set its flag");
	a_irq_quiet_none:   assert property (((flags & en_ff) == 32'h0000_0000) |=> !irq_o)
		else $error("IRQ raised with no enabled flag");
	a_irq_has_cause:    assert property ($rose(irq_o) |-> $past((flags & en_ff) != 32'h0000_0000))
		else $error("IRQ rose without an enabled flag");

	// Disabled sources never reach the line on their own
	a_iso_irq_mute:     assert property (p_mute(hise_pkg::ISO_BIT))
		else $error("disabled isochronous flag raised IRQ");
	a_async_irq_mute:   assert property (p_mute(hise_pkg::ASYNC_BIT))
		else $error("disabled async flag raised IRQ");
	a_intr_irq_mute:    assert property (p_mute(hise_pkg::INTR_BIT))
		else $error("disabled interrupt transfer flag raised IRQ");
	a_clk_irq_mute:     assert property (p_mute(hise_pkg::CLK_BIT))
		else $error("disabled clock stable flag raised IRQ");
	a_susp_irq_mute:    assert property (p_mute(hise_pkg::SUSP_BIT))
		else $error("disabled suspend flag raised IRQ");
	a_dma_irq_mute:     assert property (p_mute(hise_pkg::DMA_BIT))
		else $error("disabled DMA flag raised IRQ");

	// Write-one-to-clear drops a flag unless its event lands in the same cycle
	a_clear_drops_flag: assert property (wr_flags |=>
		((flags & $past(ev_clr & ~ev_set)) == 32'h0000_0000))
		else $error("cleared flag did not drop");
	a_set_beats_clear:  assert property ((ev_set != 32'h0000_0000) |=>
		((flags & $past(ev_set)) == $past(ev_set)))
		else $error("event lost against a clear");

	// Enable writes land next cycle, reserved enables stay zero and status bit 4 reads zero
	a_en_write_lands:   assert property (wr_en |=>
		(en_ff == $past(bus_wdata_i & hise_pkg::SRC_MASK)))
		else $error("enable write did not land");
	a_rsvd_en_zero:     assert property ((en_ff & ~hise_pkg::SRC_MASK) == 32'h0000_0000)
		else $error("reserved enable bit stored");
	a_rsvd4_reads_zero: assert property (status_word[hise_pkg::RSVD4_BIT] == 1'b0)
		else $error("reserved status bit 4 read one");

	// A taken read shows the addressed word one cycle later
	property p_read(logic [15:0] ofs, logic [31:0] word);
		(rd_any && hit(bus_addr_i, ofs)) |=> (bus_rdata_o == $past(word));
	endproperty

	a_read_status:      assert property (p_read(hise_pkg::IRQ_EVENT_FLAGS_OFS, status_word))
		else $error("status read returned the wrong word");
	a_read_enables:     assert property (p_read(hise_pkg::IRQ_SOURCE_ENABLES_OFS, en_ff))
		else $error("enable read returned the wrong word");

endmodule // hise_top

`default_nettype wire

// >>> hise_pkg.sv
// Shared constants for the host interrupt status and enable block
package hise_pkg;

	// Register byte offsets on the processor interface
	localparam logic [15:0] IRQ_EVENT_FLAGS_OFS    = 16'h0310;
	localparam logic [15:0] IRQ_SOURCE_ENABLES_OFS = 16'h0314;

	// Bit positions shared by the status and enable registers
	localparam int ISO_BIT     = 9;
	localparam int ASYNC_BIT   = 8;
	localparam int INTR_BIT    = 7;
	localparam int CLK_BIT     = 6;
	localparam int SUSP_BIT    = 5;
	localparam int RSVD4_BIT   = 4;
	localparam int DMA_BIT     = 3;
	localparam int RSVD2_BIT   = 2;
	localparam int SOF_BIT     = 1;
	localparam int RSVD0_BIT   = 0;

	// Bits that hold a live flag or enable
	localparam logic [31:0] SRC_MASK = 32'h0000_03ea;

	// Reset values
	localparam logic [31:0] ENABLES_RST = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RST   = 32'h0000_0000;

	// Settling time of the reserved status bits after reset
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_NS     = 1000;
	// Least time: round up to whole cycles
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> hise_flag_bank.sv
// Bank of sticky event flags, set by hardware and cleared by software
`timescale 1ns/1ns
`default_nettype none

module hise_flag_bank #(
	parameter int WIDTH = 32
) (
	input  wire  logic             clock_i,  // Core clock
	input  wire  logic             srst_i,   // Synchronous reset
	input  wire  logic [WIDTH-1:0] set_i,    // Event pulses
	input  wire  logic [WIDTH-1:0] clr_i,    // Clear pulses
	output logic       [WIDTH-1:0] flags_o   // Sticky flags
);

	// Refuse a bank with no flags
	if (WIDTH < 1) begin : g_bad_width
		$error("hise_flag_bank: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] flags_ff;      // Flag state
	logic [WIDTH-1:0] nxt_flags;     // Next flag state

	// One flag per bit: a set in the clearing cycle wins
	for (genvar i = 0; i < WIDTH; i++) begin : g_flag
		always_comb begin
			if (set_i[i]) begin
				nxt_flags[i] = 1'b1;
			end else if (clr_i[i]) begin
				nxt_flags[i] = 1'b0;
			end else begin
				nxt_flags[i] = flags_ff[i];
			end
		end
	end

	// Register the flags
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign flags_o = flags_ff;

endmodule // hise_flag_bank

`default_nettype wire

// >>> hise_cpu_model.sv
// Processor model that reaches the status and enable registers
`timescale 1ns/1ns
`default_nettype none

module hise_cpu_model (
	input  wire logic        clock_i,  // Core clock
	output logic             sel_o,    // Access select
	output logic             wr_o,     // Write strobe
	output logic             rd_o,     // Read strobe
	output logic [15:0]      addr_o,   // Byte address
	output logic [31:0]      wdata_o,  // Write data
	input  wire logic [31:0] rdata_i   // Read data
);
	// Idle bus at time zero
	initial begin
		sel_o   = 1'b0;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		addr_o  = 16'h0000;
		wdata_o = 32'h0000_0000;
	end

	// Released lines never keep showing the last value
	task automatic release_bus();
		sel_o   = 1'b0;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		addr_o  = ~addr_o;
		wdata_o = ~wdata_o;
	endtask

	// One write, taken at the rising edge inside the held window
	task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
		@(negedge clock_i);
		sel_o   = 1'b1;
		wr_o    = 1'b1;
		addr_o  = a;
		wdata_o = d & hise_pkg::SRC_MASK;
		@(negedge clock_i);
		release_bus();
	endtask

	// One read, data sampled at the falling edge half a cycle after the taken edge
	task automatic read_reg(input logic [15:0] a, output logic [31:0] d);
		@(negedge clock_i);
		sel_o  = 1'b1;
		rd_o   = 1'b1;
		addr_o = a;
		@(negedge clock_i);
		d = rdata_i;
		release_bus();
	endtask
endmodule // hise_cpu_model

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the interrupt status and enable block
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam int SETTLE = 8;                   // Short settle for the run
	localparam logic [31:0] RSVD = 32'h0000_0005; // Settled reserved bits
	localparam int BITS [7] = '{9, 8, 7, 6, 5, 3, 1}; // Flag bit per event
	logic        clock_i;  // Core clock
	logic        srst_i;   // Reset
	logic        sel;      // Bus select
	logic        wr;       // Bus write
	logic        rd;       // Bus read
	logic [15:0] addr;     // Bus address
	logic [31:0] wdata;    // Bus write data
	logic [31:0] rdata;    // Bus read data
	logic [6:0]  ev;       // Event pulses
	logic        irq;      // IRQ line
	logic [31:0] rd_v;     // Last read value
	int          fails;    // Mismatches
	int          n_checks; // Comparisons

	hise_cpu_model hise_cpu_model_i (.clock_i(clock_i), .sel_o(sel), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

	hise_top #(.ADDR_W(16), .SETTLE(SETTLE)) hise_top_i (.clock_i(clock_i), .srst_i(srst_i),
		.bus_sel_i(sel), .bus_wr_i(wr), .bus_rd_i(rd), .bus_addr_i(addr),
		.bus_wdata_i(wdata), .bus_rdata_o(rdata), .frame_start_i(ev[6]),
		.iso_done_i(ev[0]), .async_done_i(ev[1]), .intr_done_i(ev[2]),
		.clk_stable_i(ev[3]), .suspend_entry_i(ev[4]), .dma_done_i(ev[5]), .irq_o(irq));

	// Clock, 4 ns period
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask

	// One-cycle pulse on an event input
	task automatic pulse(input int i);
		@(negedge clock_i);
		ev[i] = 1'b1;
		@(negedge clock_i);
		ev[i] = 1'b0;
	endtask

	// Counts and verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard
	initial begin
		#20000;
		fails++;
		give_verdict();
	end

	// Main sequence
	initial begin
		srst_i   = 1'b1;
		ev       = 7'h00;
		fails    = 0;
		n_checks = 0;
		repeat (5) @(negedge clock_i);
		srst_i = 1'b0;
		hise_cpu_model_i.read_reg(16'h0310, rd_v);
		chk(rd_v, 32'h0);
		hise_cpu_model_i.read_reg(16'h0314, rd_v);
		chk(rd_v, 32'h0);
		repeat (SETTLE) @(negedge clock_i);
		hise_cpu_model_i.read_reg(16'h0310, rd_v);
		chk(rd_v, RSVD);
		// Unmapped place takes nothing and reads zero
		hise_cpu_model_i.write_reg(16'h0318, 32'h0000_03ea);
		hise_cpu_model_i.read_reg(16'h0318, rd_v);
		chk(rd_v, 32'h0);
		hise_cpu_model_i.read_reg(16'h0314, rd_v);
		chk(rd_v, 32'h0);
		// Each source: disabled, then enabled
		for (int i = 0; i < 7; i++) begin
			pulse(i);
			repeat (2) @(negedge clock_i);
			chk({31'h0, irq}, 32'h0);
			hise_cpu_model_i.read_reg(16'h0310, rd_v);
			chk(rd_v, RSVD | (32'h1 << BITS[i]));
			hise_cpu_model_i.write_reg(16'h0314, 32'h1 << BITS[i]);
			@(negedge clock_i);
			chk({31'h0, irq}, 32'h1);
			hise_cpu_model_i.write_reg(16'h0310, 32'h1 << BITS[i]);
			@(negedge clock_i);
			chk({31'h0, irq}, 32'h0);
			pulse(i);
			repeat (2) @(negedge clock_i);
			chk({31'h0, irq}, 32'h1);
			hise_cpu_model_i.write_reg(16'h0314, 32'h0);
			@(negedge clock_i);
			chk({31'h0, irq}, 32'h0);
			hise_cpu_model_i.write_reg(16'h0310, 32'h0000_03ea);
			hise_cpu_model_i.read_reg(16'h0310, rd_v);
			chk(rd_v, RSVD);
		end
		// All enables, two sources, cleared one at a time
		hise_cpu_model_i.write_reg(16'h0314, 32'hffff_ffff);
		hise_cpu_model_i.read_reg(16'h0314, rd_v);
		chk(rd_v, 32'h0000_03ea);
		pulse(6);
		pulse(5);
		repeat (2) @(negedge clock_i);
		hise_cpu_model_i.write_reg(16'h0310, 32'h0000_0002);
		@(negedge clock_i);
		chk({31'h0, irq}, 32'h1);
		hise_cpu_model_i.write_reg(16'h0310, 32'h0000_0008);
		@(negedge clock_i);
		chk({31'h0, irq}, 32'h0);
		// Second reset in mid-run clears flags, enables, IRQ and reserved bits
		pulse(6);
		repeat (2) @(negedge clock_i);
		chk({31'h0, irq}, 32'h1);
		srst_i = 1'b1;
		repeat (2) @(negedge clock_i);
		srst_i = 1'b0;
		chk({31'h0, irq}, 32'h0);
		hise_cpu_model_i.read_reg(16'h0310, rd_v);
		chk(rd_v, 32'h0);
		hise_cpu_model_i.read_reg(16'h0314, rd_v);
		chk(rd_v, 32'h0);
		give_verdict();
	end
endmodule // testbench

`default_nettype wire
